// >>> src/mlb_fabric.sv
/*
  Top of the sum-of-products logic fabric: eight blocks of sixteen
  macrocells, central routing matrix, pin keepers, global clock edge
  detection and the Avalon-MM configuration slave.
  Assumes all pins are synchronous to CLK_I; global clocks are sampled.
*/
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
// Behaviour
// [R01] There are eight blocks, each with one term array, one allocator and 16 macrocells.
// [R02] Each term array takes 36 routed inputs in both polarities and makes 86 terms.
// [R03] Each macrocell may be given any number of terms from zero to sixteen.
// [R04] One term may feed several macrocells of its block at the same time.
// [R05] A macrocell sums its terms by OR, and an empty sum is low.
// [R06] A macrocell can invert its sum before register and output path.
// [R07] A macrocell has one register that can be used or bypassed.
// [R08] The register takes its value on the edge of one of four global clocks.
// [R09] A macrocell feeds its result back to the routing apart from its pin.
// [R10] Every block input, feedback or pin, passes only through the routing matrix.
// [R11] Each macrocell has its own pin, 128 in all, usable as output or input.
// [R12] One input-only pin and four pins that are global clocks or inputs exist.
// [R13] Every pin keeps its last level while nothing drives it.
// [R14] All configuration is static and cannot change while the fabric runs.
`timescale 1ns/1ps
module mlb_fabric
  import mlb_pkg::*;
#(
  parameter int N_BLK = NUM_BLK,
  parameter int N_MC = NUM_MC
) (
  input wire logic CLK_I, // fabric clock
  input wire logic RESET_I, // sync reset, high
  input wire logic CE_I, // clock enable
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I, // byte address
  input wire logic AVS_READ_I, // read request
  input wire logic AVS_WRITE_I, // write request
  input wire logic [31:0] AVS_WRITEDATA_I, // write data
  input wire logic [3:0] AVS_BYTEENABLE_I, // byte enables
  output logic [31:0] AVS_READDATA_O, // read data
  output logic AVS_WAITREQUEST_O, // stall
  input wire logic [NUM_PIN-1:0] IO_IN_I, // pin level in
  input wire logic [NUM_PIN-1:0] IO_DRV_I, // pin driven outside
  output logic [NUM_PIN-1:0] IO_OUT_O, // pin level out
  output logic [NUM_PIN-1:0] IO_OE_O, // pin drive enable
  input wire logic [NUM_DED-1:0] DED_IN_I, // 3:0 clock pins, 4 input
  input wire logic [NUM_DED-1:0] DED_DRV_I // dedicated pin driven
);
  localparam int N_CELL = N_BLK * N_MC;

  typedef struct packed {
    logic resp;
    logic [31:0] rdata;
    logic run;
    logic refused;
    logic [NUM_GCLK-1:0] clk_prev;
    logic [NUM_PIN-1:0] io_hold;
    logic [NUM_DED-1:0] ded_hold;
  } mlb_top_t;

  mlb_top_t st;
  mlb_top_t next_st;

  logic [SEL_W-1:0] route_sel [N_BLK][NUM_RIN];
  logic [N_CELL-1:0] mc_out;
  logic [N_CELL-1:0] mc_oe;
  logic [NUM_PIN-1:0] pin_lvl;
  logic [NUM_DED-1:0] ded_lvl;
  logic [NUM_SRC-1:0] src;
  logic [NUM_RIN-1:0] routed [N_BLK];
  logic [NUM_TERM-1:0] terms [N_BLK];
  logic [NUM_GCLK-1:0] clk_rise;

  logic req;
  logic wr_go;
  logic cfg_ok;
  logic [1:0] region;
  logic [2:0] blk;
  logic [IDX_W-1:0] term_idx;
  logic [3:0] mc_idx;
  logic [5:0] rin_idx;
  logic [3:0] stat_idx;
  logic [2:0] word3;
  logic [31:0] rd_val;
  logic [31:0] wmask;

  function automatic logic route_pick(input logic [NUM_SRC-1:0] s,
                                      input logic [SEL_W-1:0] sel);
    logic r;
    r = 1'b0;
    if (int'(sel) < NUM_SRC) begin
      r = s[sel];
    end
    return r;
  endfunction

  // bus decode; one wait state, answer at the second edge
  assign req = AVS_READ_I || AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = req && !(st.resp && CE_I);
  assign AVS_READDATA_O = st.rdata;
  assign wr_go = AVS_WRITE_I && st.resp;
  assign cfg_ok = !st.run; // [R14]
  assign region = AVS_ADDRESS_I[REGION_LSB +: 2];
  assign blk = AVS_ADDRESS_I[BLK_LSB +: 3];
  assign term_idx = AVS_ADDRESS_I[TERM_LSB +: IDX_W];
  assign mc_idx = AVS_ADDRESS_I[MC_LSB +: 4];
  assign rin_idx = AVS_ADDRESS_I[WORD_LSB +: 6];
  assign stat_idx = AVS_ADDRESS_I[WORD_LSB +: 4];
  assign word3 = AVS_ADDRESS_I[WORD_LSB +: 3];
  assign wmask = be_mask(AVS_BYTEENABLE_I);

  // pins: own drive first, then outside driver, else the keeper
  always_comb begin
    for (int i = 0; i < NUM_PIN; i++) begin
      if (mc_oe[i]) begin
        pin_lvl[i] = mc_out[i]; // [R11]
      end else if (IO_DRV_I[i]) begin
        pin_lvl[i] = IO_IN_I[i];
      end else begin
        pin_lvl[i] = st.io_hold[i]; // [R13]
      end
    end
    for (int d = 0; d < NUM_DED; d++) begin
      ded_lvl[d] = DED_DRV_I[d] ? DED_IN_I[d] : st.ded_hold[d]; // [R13]
    end
  end

  assign IO_OUT_O = mc_out[NUM_PIN-1:0];
  assign IO_OE_O = mc_oe[NUM_PIN-1:0];

  // feedback taken from the cell, not the pin, so buried registers work
  assign src = {ded_lvl, pin_lvl, mc_out[NUM_PIN-1:0]}; // [R09] [R12]

  // clock edges only count while running so config stays quiet
  assign clk_rise = st.run ? (ded_lvl[NUM_GCLK-1:0] & ~st.clk_prev)
                           : '0; // [R12]

  // routing matrix: the only way into a block
  always_comb begin
    for (int b = 0; b < N_BLK; b++) begin
      for (int j = 0; j < NUM_RIN; j++) begin
        routed[b][j] = route_pick(src, route_sel[b][j]); // [R10]
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      for (int b = 0; b < N_BLK; b++) begin
        for (int j = 0; j < NUM_RIN; j++) begin
          route_sel[b][j] <= SEL_NONE;
        end
      end
    end else if (CE_I && wr_go && cfg_ok && region == REGION_ROUTE
                 && int'(blk) < N_BLK && int'(rin_idx) < NUM_RIN) begin
      route_sel[blk][rin_idx] <= SEL_W'(
        ({23'h0, route_sel[blk][rin_idx]} & ~wmask)
        | (AVS_WRITEDATA_I & wmask)); // [R14]
    end
  end

  // eight blocks of term array plus sixteen macrocells
  for (genvar b = 0; b < N_BLK; b++) begin : g_blk
    mlb_term_array #(
      .N_IN(NUM_RIN),
      .N_TERM(NUM_TERM)
    ) u_array (
      .clk_i(CLK_I),
      .rst_i(RESET_I),
      .ce_i(CE_I),
      .wr_i(wr_go && cfg_ok && region == REGION_TERM
            && int'(blk) == b),
      .term_i(term_idx),
      .word_i(AVS_ADDRESS_I[WORD_LSB +: 2]),
      .data_i(AVS_WRITEDATA_I),
      .be_i(AVS_BYTEENABLE_I),
      .sig_i(routed[b]),
      .term_o(terms[b])
    ); // [R01] [R02]
    for (genvar m = 0; m < N_MC; m++) begin : g_mc
      mlb_macrocell #(
        .N_TERM(NUM_TERM)
      ) u_cell (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .ce_i(CE_I),
        .wr_i(wr_go && cfg_ok && region == REGION_ALLOC
              && int'(blk) == b && int'(mc_idx) == m
              && AVS_ADDRESS_I[6:5] == 2'h0),
        .word_i(word3),
        .data_i(AVS_WRITEDATA_I),
        .be_i(AVS_BYTEENABLE_I),
        .term_i(terms[b]),
        .clk_rise_i(clk_rise),
        .out_o(mc_out[b*N_MC+m]),
        .oe_o(mc_oe[b*N_MC+m])
      ); // [R01] [R04]
    end
  end

  // read mux: routing selects and live state; other config reads zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (region == REGION_ROUTE && int'(blk) < N_BLK
        && int'(rin_idx) < NUM_RIN) begin
      rd_val = {23'h0, route_sel[blk][rin_idx]};
    end else if (region == REGION_STAT) begin
      if (int'(stat_idx) == STAT_CTRL) begin
        rd_val[RUN_BIT] = st.run;
        rd_val[REFUSED_BIT] = st.refused;
      end else if (int'(stat_idx) >= STAT_MC
                   && int'(stat_idx) < STAT_PIN) begin
        rd_val = mc_out[32*(stat_idx-4'(STAT_MC)) +: 32];
      end else if (int'(stat_idx) >= STAT_PIN
                   && int'(stat_idx) < STAT_DED) begin
        rd_val = pin_lvl[32*(stat_idx-4'(STAT_PIN)) +: 32];
      end else if (int'(stat_idx) == STAT_DED) begin
        rd_val[NUM_DED-1:0] = ded_lvl;
      end
    end
  end

  always_comb begin
    next_st = st;
    next_st.resp = req && !st.resp;
    if (req && !st.resp) begin
      next_st.rdata = AVS_READ_I ? rd_val : st.rdata;
    end
    next_st.io_hold = pin_lvl; // [R13]
    next_st.ded_hold = ded_lvl;
    next_st.clk_prev = ded_lvl[NUM_GCLK-1:0];
    if (wr_go && region == REGION_STAT
        && int'(stat_idx) == STAT_CTRL && AVS_BYTEENABLE_I[0]) begin
      next_st.run = AVS_WRITEDATA_I[RUN_BIT];
      if (AVS_WRITEDATA_I[REFUSED_BIT]) begin
        next_st.refused = 1'b0;
      end
    end
    // a refused write while running is flagged; set beats clear
    if (wr_go && !cfg_ok && region != REGION_STAT) begin
      next_st.refused = 1'b1; // [R14]
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      st <= '0;
    end else if (CE_I) begin
      st <= next_st;
    end
  end

  property p_refuse;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && wr_go && st.run && region != REGION_STAT)
      |=> st.refused && st.run;
  endproperty
  a_refuse: assert property (p_refuse) // [R14]
    else $error("config write while running not flagged");

  property p_route;
    @(posedge CLK_I) disable iff (RESET_I)
    (int'(route_sel[0][0]) < NUM_SRC)
      |-> routed[0][0] == src[route_sel[0][0]];
  endproperty
  a_route: assert property (p_route) // [R10]
    else $error("routed input does not follow its source");

  property p_keep;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && !IO_OE_O[0]) ##1 (!IO_OE_O[0] && !IO_DRV_I[0])
      |-> pin_lvl[0] == $past(pin_lvl[0]);
  endproperty
  a_keep: assert property (p_keep) // [R13]
    else $error("undriven pin lost its level");

  property p_pin_out;
    @(posedge CLK_I) disable iff (RESET_I)
    IO_OE_O[0] |-> pin_lvl[0] == IO_OUT_O[0] && src[NUM_PIN] == IO_OUT_O[0];
  endproperty
  a_pin_out: assert property (p_pin_out) // [R11]
    else $error("driven pin does not show its cell");

  property p_gclk;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && st.run && !ded_lvl[2]) ##1 (st.run && ded_lvl[2])
      |-> clk_rise[2];
  endproperty
  a_gclk: assert property (p_gclk) // [R12]
    else $error("global clock edge not detected");

  property p_answer;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && req && !st.resp) |=> st.resp;
  endproperty
  a_answer: assert property (p_answer) // [R14]
    else $error("bus request got no answer");

  property p_route_static;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && st.run) |=> $stable(route_sel[0][0]);
  endproperty
  a_route_static: assert property (p_route_static) // [R14]
    else $error("routing changed while running");

  property p_clear;
    @(posedge CLK_I) disable iff (RESET_I)
    (CE_I && wr_go && region == REGION_STAT
      && int'(stat_idx) == STAT_CTRL && AVS_BYTEENABLE_I[0]
      && AVS_WRITEDATA_I[REFUSED_BIT]) |=> !st.refused;
  endproperty
  a_clear: assert property (p_clear) // [R14]
    else $error("refused flag not cleared");

  property p_pin_in;
    @(posedge CLK_I) disable iff (RESET_I)
    (!IO_OE_O[100] && IO_DRV_I[100]) |-> pin_lvl[100] == IO_IN_I[100];
  endproperty
  a_pin_in: assert property (p_pin_in) // [R11]
    else $error("input pin level not taken");

  property p_feedback;
    @(posedge CLK_I) disable iff (RESET_I)
    (IO_DRV_I[4] && !IO_OE_O[4])
      |-> src[4] == IO_OUT_O[4] && src[NUM_PIN+4] == IO_IN_I[4];
  endproperty
  a_feedback: assert property (p_feedback) // [R09]
    else $error("feedback follows the pin, not the cell");

  property p_keep_ded;
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I ##1 !DED_DRV_I[4] |-> ded_lvl[4] == $past(ded_lvl[4]);
  endproperty
  a_keep_ded: assert property (p_keep_ded) // [R13]
    else $error("undriven input pin lost its level");

  property p_idle_clk;
    @(posedge CLK_I) disable iff (RESET_I)
    !st.run |-> clk_rise == '0;
  endproperty
  a_idle_clk: assert property (p_idle_clk) // [R14]
    else $error("clock edge seen while stopped");
endmodule

// >>> src/mlb_macrocell.sv
/*
  One macrocell: sum of up to sixteen steered terms, polarity,
  bypassable register on a selectable global clock edge, pin enable.
  Assumes clock edges arrive as one-cycle rise strobes.
*/
`timescale 1ns/1ps
module mlb_macrocell
  import mlb_pkg::*;
#(
  parameter int N_TERM = NUM_TERM
) (
  input wire logic clk_i, // fabric clock
  input wire logic rst_i, // sync reset
  input wire logic ce_i, // clock enable
  input wire logic wr_i, // config write strobe
  input wire logic [2:0] word_i, // config word
  input wire logic [31:0] data_i, // write data
  input wire logic [3:0] be_i, // byte enables
  input wire logic [N_TERM-1:0] term_i, // block terms
  input wire logic [NUM_GCLK-1:0] clk_rise_i, // global clock edges
  output logic out_o, // macrocell result
  output logic oe_o // pin output enable
);
  typedef struct packed {
    logic [NUM_SLOT-1:0][IDX_W-1:0] slot;
    logic inv;
    logic byp;
    logic [1:0] csel;
    logic oe;
    logic q;
  } mlb_mc_t;

  localparam mlb_mc_t MC_RESET = '{slot: {NUM_SLOT{SLOT_EMPTY}},
                                   default: '0};
  mlb_mc_t st;
  mlb_mc_t next_st;
  logic sum;
  logic val;

  always_comb begin
    next_st = st;
    sum = 1'b0;
    // a term may sit in several slots and several macrocells at once
    for (int s = 0; s < NUM_SLOT; s++) begin
      if (int'(st.slot[s]) < N_TERM) begin
        sum = sum | term_i[st.slot[s]]; // [R03] [R04] [R05]
      end
    end
    val = sum ^ st.inv; // [R06]
    if (clk_rise_i[st.csel]) begin
      next_st.q = val; // [R08]
    end
    if (wr_i && int'(word_i) == ALLOC_CTRL_WORD && be_i[0]) begin
      next_st.inv = data_i[CTL_INV];
      next_st.byp = data_i[CTL_BYP];
      next_st.csel = data_i[CTL_CSEL +: 2];
      next_st.oe = data_i[CTL_OE];
    end else if (wr_i && int'(word_i) < ALLOC_CTRL_WORD) begin
      for (int k = 0; k < 4; k++) begin
        if (be_i[k]) begin
          next_st.slot[4*word_i+k] = data_i[8*k +: IDX_W];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= MC_RESET;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign out_o = st.byp ? val : st.q; // [R07]
  assign oe_o = st.oe;

  property p_empty_sum;
    @(posedge clk_i) disable iff (rst_i)
    (st.slot == {NUM_SLOT{SLOT_EMPTY}}) |-> !sum;
  endproperty
  a_empty_sum: assert property (p_empty_sum) // [R05]
    else $error("empty sum is not low");

  property p_polarity;
    @(posedge clk_i) disable iff (rst_i)
    st.byp |-> out_o == (st.inv ? !sum : sum);
  endproperty
  a_polarity: assert property (p_polarity) // [R06]
    else $error("bypassed output has wrong polarity");

  property p_capture;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && clk_rise_i[st.csel]) |=> st.q == $past(val);
  endproperty
  a_capture: assert property (p_capture) // [R08]
    else $error("register missed selected clock edge");

  property p_reg_hold;
    @(posedge clk_i) disable iff (rst_i)
    (!st.byp && !wr_i && !clk_rise_i[st.csel]) ##1 !st.byp
      |-> out_o == $past(out_o);
  endproperty
  a_reg_hold: assert property (p_reg_hold) // [R07]
    else $error("registered output changed without edge");
endmodule

// >>> src/mlb_pkg.sv
/*
  Shared constants for the sum-of-products logic fabric: array sizes,
  register map field positions, reset values and small helpers.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package mlb_pkg;
  localparam int NUM_BLK = 8;
  localparam int NUM_MC = 16;
  localparam int NUM_RIN = 36;
  localparam int NUM_TERM = 86;
  localparam int NUM_SLOT = 16;
  localparam int IDX_W = 7;
  localparam int SEL_W = 9;
  localparam int NUM_PIN = 128;
  localparam int NUM_DED = 5;
  localparam int NUM_GCLK = 4;
  localparam int NUM_SRC = 261;
  localparam int ADDR_W = 16;
  // byte address fields
  localparam int REGION_LSB = 14;
  localparam int BLK_LSB = 11;
  localparam int TERM_LSB = 4;
  localparam int MC_LSB = 7;
  localparam int WORD_LSB = 2;
  localparam logic [1:0] REGION_TERM = 2'h0;
  localparam logic [1:0] REGION_ALLOC = 2'h1;
  localparam logic [1:0] REGION_ROUTE = 2'h2;
  localparam logic [1:0] REGION_STAT = 2'h3;
  localparam int TERM_WORDS = 3;
  localparam int ALLOC_CTRL_WORD = 4;
  // macrocell control word bits
  localparam int CTL_INV = 0;
  localparam int CTL_BYP = 1;
  localparam int CTL_CSEL = 2;
  localparam int CTL_OE = 4;
  // status region word indices
  localparam int STAT_CTRL = 0;
  localparam int STAT_MC = 1;
  localparam int STAT_PIN = 5;
  localparam int STAT_DED = 9;
  localparam int RUN_BIT = 0;
  localparam int REFUSED_BIT = 1;
  localparam logic [IDX_W-1:0] SLOT_EMPTY = 7'h7F;
  localparam logic [SEL_W-1:0] SEL_NONE = 9'h1FF;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int k = 0; k < 4; k++) begin
      m[8*k +: 8] = {8{be[k]}};
    end
    return m;
  endfunction
endpackage

// >>> src/mlb_term_array.sv
/*
  Product-term array of one logic block: AND of any true or complement
  literals of the routed inputs. Mask memory written word by word.
  Assumes writes only arrive while the fabric is stopped.
*/
`timescale 1ns/1ps
module mlb_term_array
  import mlb_pkg::*;
#(
  parameter int N_IN = NUM_RIN,
  parameter int N_TERM = NUM_TERM
) (
  input wire logic clk_i, // fabric clock
  input wire logic rst_i, // sync reset
  input wire logic ce_i, // clock enable
  input wire logic wr_i, // mask write strobe
  input wire logic [IDX_W-1:0] term_i, // term index
  input wire logic [1:0] word_i, // mask word
  input wire logic [31:0] data_i, // write data
  input wire logic [3:0] be_i, // byte enables
  input wire logic [N_IN-1:0] sig_i, // routed inputs
  output logic [N_TERM-1:0] term_o // product terms
);
  logic [2*N_IN-1:0] and_mask [N_TERM];
  logic [95:0] cur;
  logic [95:0] upd;
  logic [31:0] m;
  logic wr_ok;

  assign wr_ok = wr_i && int'(term_i) < N_TERM
                 && int'(word_i) < TERM_WORDS;

  always_comb begin
    cur = '0;
    m = be_mask(be_i);
    if (int'(term_i) < N_TERM) begin
      cur[2*N_IN-1:0] = and_mask[term_i];
    end
    upd = cur;
    if (int'(word_i) < TERM_WORDS) begin
      upd[32*word_i +: 32] = (cur[32*word_i +: 32] & ~m) | (data_i & m);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int t = 0; t < N_TERM; t++) begin
        and_mask[t] <= '0;
      end
    end else if (ce_i && wr_ok) begin
      and_mask[term_i] <= upd[2*N_IN-1:0];
    end
  end

  // empty mask reads as an unused term, not a constant one
  always_comb begin
    for (int t = 0; t < N_TERM; t++) begin
      term_o[t] = (|and_mask[t]) &&
                  (&({~sig_i, sig_i} | ~and_mask[t])); // [R02]
    end
  end

  property p_term_empty;
    @(posedge clk_i) disable iff (rst_i)
    (and_mask[0] == '0) |-> !term_o[0];
  endproperty
  a_term_empty: assert property (p_term_empty) // [R02]
    else $error("unprogrammed term is high");

  property p_term_lit;
    @(posedge clk_i) disable iff (rst_i)
    (and_mask[N_TERM-1] == {{(N_IN-1){1'b0}}, 1'b1, {N_IN{1'b0}}})
      |-> term_o[N_TERM-1] == !sig_i[0];
  endproperty
  a_term_lit: assert property (p_term_lit) // [R02]
    else $error("complement literal not applied");
endmodule

// >>> tb/mlb_fabric_test.sv
/*
  Self-checking bench for the logic fabric: config over Avalon-MM,
  pin stimulus through the pin model, checks at the pins and status.
  Assumes the default parameters; CE_I drops once to check the freeze.
*/
`timescale 1ns/1ps
module mlb_fabric_test
  import mlb_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic rd_r = 1'b0;
  logic wr_r = 1'b0;
  logic [31:0] wd = '0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic wait_r;
  logic [NUM_PIN-1:0] io_in, io_drv, io_out, io_oe;
  logic [NUM_DED-1:0] ded_in, ded_drv;
  int n_fail = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  mlb_fabric uut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_r), .AVS_WRITE_I(wr_r),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_r),
    .IO_IN_I(io_in), .IO_DRV_I(io_drv), .IO_OUT_O(io_out),
    .IO_OE_O(io_oe), .DED_IN_I(ded_in), .DED_DRV_I(ded_drv));

  mlb_pins_model pins (.clk_i(clk), .io_oe_i(io_oe), .io_in_o(io_in),
    .io_drv_o(io_drv), .ded_in_o(ded_in), .ded_drv_o(ded_drv));

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] ta(input int b, input int t,
                                     input int w);
    return {REGION_TERM, b[2:0], t[6:0], w[1:0], 2'h0};
  endfunction
  function automatic logic [15:0] aa(input int b, input int c,
                                     input int w);
    return {REGION_ALLOC, b[2:0], c[3:0], 2'h0, w[2:0], 2'h0};
  endfunction
  function automatic logic [15:0] ra(input int b, input int i);
    return {REGION_ROUTE, b[2:0], 3'h0, i[5:0], 2'h0};
  endfunction
  function automatic logic [15:0] sa(input int w);
    return {REGION_STAT, 8'h00, w[3:0], 2'h0};
  endfunction

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [3:0] m,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    wr_r <= w;
    rd_r <= !w;
    wd <= d;
    be <= m;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    if (wait_r !== 1'b0) begin
      n_fail++;
      results();
    end else begin
      q = rdata;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    check(q, e);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    check(32'(|io_oe), 32'h0);
    check(io_out[31:0], 32'h0);
    rdchk(ra(0, 0), 32'h000001FF);
    rdchk(sa(STAT_CTRL), 32'h0);
    rdchk(ra(0, 40), 32'h0);
    bus(1'b1, ra(0, 10), 32'h00000000, 4'h1, q);
    rdchk(ra(0, 10), 32'h00000100);
    $display("reset values done");
  endtask

  // a = pin 100 on input 0, b = input-only pin on input 35
  task automatic t_config();
    wr(ra(0, 0), 32'h000000E4);
    wr(ra(0, 35), 32'h00000104);
    wr(ra(1, 2), 32'h00000004);
    wr(ta(0, 0, 0), 32'h00000001);
    wr(ta(0, 0, 1), 32'h00000008);
    wr(ta(0, 85, 1), 32'h00000010);
    wr(ta(1, 0, 0), 32'h00000004);
    wr(aa(0, 0, 0), 32'h7F7F5500);
    wr(aa(0, 0, 4), 32'h00000012);
    wr(aa(0, 1, 0), 32'h7F7F7F00);
    wr(aa(0, 1, 4), 32'h00000003);
    wr(aa(0, 2, 4), 32'h00000002);
    for (int w = 0; w < 3; w++) wr(aa(0, 3, w), 32'h02020202);
    wr(aa(0, 3, 3), 32'h00020202);
    wr(aa(0, 3, 4), 32'h00000002);
    wr(aa(0, 4, 0), 32'h7F7F7F00);
    wr(aa(0, 4, 4), 32'h00000008);
    wr(aa(1, 0, 0), 32'h7F7F7F00);
    wr(aa(1, 0, 4), 32'h00000002);
    wr(sa(STAT_CTRL), 32'h00000001);
    pins.pin(4, 1'b0);
    $display("configuration done");
  endtask

  task automatic t_comb();
    logic a, b;
    for (int k = 0; k < 4; k++) begin
      a = k[0];
      b = k[1];
      pins.pin(100, a);
      pins.ded(4, b);
      settle();
      check(io_out[0], (a & b) | !a);
      check(io_out[1], !(a & b));
      check(io_out[2], 1'b0);
      check(io_out[3], a & b);
      check(io_oe[1:0], 2'b01);
    end
    $display("combinational paths done");
  endtask

  task automatic t_reg();
    check(io_out[4], 1'b0);
    pins.ded(1, 1'b1);
    settle();
    check(io_out[4], 1'b0);
    pins.ded(2, 1'b1);
    settle();
    check(io_out[4], 1'b1);
    check(io_out[16], 1'b1);
    pins.pin(100, 1'b0);
    settle();
    check(io_out[4], 1'b1);
    pins.ded(2, 1'b0);
    pins.ded(2, 1'b1);
    settle();
    check(io_out[4], 1'b0);
    check(io_out[16], 1'b0);
    check(io_oe[4], 1'b0);
    $display("register paths done");
  endtask

  task automatic t_refuse();
    wr(ra(0, 0), 32'h00000000);
    rdchk(ra(0, 0), 32'h000000E4);
    rdchk(sa(STAT_CTRL), 32'h00000003);
    wr(sa(STAT_CTRL), 32'h00000003);
    rdchk(sa(STAT_CTRL), 32'h00000001);
    $display("static configuration done");
  endtask

  task automatic t_hold();
    logic [31:0] q;
    pins.pin(100, 1'b1);
    pins.ded(4, 1'b1);
    settle();
    pins.unpin(100);
    pins.unded(4);
    settle();
    bus(1'b0, sa(STAT_PIN + 3), 32'h0, 4'hF, q);
    check(q[4], 1'b1);
    bus(1'b0, sa(STAT_DED), 32'h0, 4'hF, q);
    check(q[4], 1'b1);
    check(io_out[3], 1'b1);
    check(pins.n_clash, 32'h0);
    $display("pin hold done");
  endtask

  // edge memory freezes too, so a rise during the freeze is lost
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    pins.ded(2, 1'b0);
    pins.ded(2, 1'b1);
    settle();
    check(io_out[4], 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    settle();
    check(io_out[4], 1'b0);
    pins.ded(2, 1'b0);
    pins.ded(2, 1'b1);
    settle();
    check(io_out[4], 1'b1);
    $display("clock enable done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_comb();
    t_reg();
    t_refuse();
    t_hold();
    t_freeze();
    results();
  end

  // the tests need under 2000 cycles
  initial begin
    #100000;
    n_fail++;
    results();
  end
endmodule

// >>> tb/mlb_pins_model.sv
/*
  Outside logic on the general I/O and dedicated pins of the fabric.
  Assumes the bench calls its tasks; each change lands after a rising edge.
*/
`timescale 1ns/1ps
module mlb_pins_model
  import mlb_pkg::*;
(
  input wire logic clk_i, // fabric clock
  input wire logic [NUM_PIN-1:0] io_oe_i, // device drive enables
  output logic [NUM_PIN-1:0] io_in_o, // level put on pins
  output logic [NUM_PIN-1:0] io_drv_o, // outside driver active
  output logic [NUM_DED-1:0] ded_in_o, // dedicated pin levels
  output logic [NUM_DED-1:0] ded_drv_o // dedicated pins driven
);
  int n_clash = 0;
  initial begin
    io_in_o = '0;
    io_drv_o = '0;
    ded_in_o = '0;
    ded_drv_o = '1;
  end
  task automatic pin(input int n, input logic v);
    @(posedge clk_i);
    io_in_o[n] <= v;
    io_drv_o[n] <= 1'b1;
  endtask
  // a released line shows the inverse, so only the keeper holds it
  task automatic unpin(input int n);
    @(posedge clk_i);
    io_in_o[n] <= ~io_in_o[n];
    io_drv_o[n] <= 1'b0;
  endtask
  // bits 3:0 act as global clocks, bit 4 as plain input
  task automatic ded(input int n, input logic v);
    @(posedge clk_i);
    ded_in_o[n] <= v;
    ded_drv_o[n] <= 1'b1;
  endtask
  task automatic unded(input int n);
    @(posedge clk_i);
    ded_in_o[n] <= ~ded_in_o[n];
    ded_drv_o[n] <= 1'b0;
  endtask
  // never fight the device on a pin it drives
  always @(posedge clk_i) begin
    if (|(io_oe_i & io_drv_o)) n_clash++;
  end
endmodule
